// ===== common/dsb_pkg.sv
// Purpose: shared constants for the double-data-rate burst sram port
// Assumes: one mclk cycle per data beat, two beats per input clock period
// Notes:   lane widths select nibble or byte masking
package dsb_pkg;

  // ==========================================================
  // geometry
  localparam int DSB_DATA_W_DEF   = 36;
  localparam int DSB_ADDR_W_DEF   = 19;
  localparam int DSB_BURST_LEN    = 2;
  localparam int DSB_BYTE_LANE_W  = 9;
  localparam int DSB_NIB_LANE_W   = 4;
  localparam int DSB_MAX_LANES    = 4;
  localparam int DSB_BUF_DEPTH    = 2;

  // ==========================================================
  // beat phases, read direction encoding and reset values
  localparam logic DSB_PHASE_K     = 1'b0;
  localparam logic DSB_PHASE_KN    = 1'b1;
  localparam logic DSB_RW_READ     = 1'b1;
  localparam logic DSB_RST_OE      = 1'b0;
  localparam logic DSB_RST_RDY     = 1'b1;
  localparam logic DSB_RST_ECHO    = 1'b0;

  // ==========================================================
  // burst sequencer
  typedef enum logic [1:0] {
    DSB_IDLE,
    DSB_WR_SECOND,
    DSB_RD_SECOND
  } dsb_state_e;

endpackage

// ===== rtl/dsb_mem.sv
// Purpose: burst word array with lane-masked write and registered read
// Assumes: write and read ports are independent, one word each per cycle
// Notes:   same-cycle read of a word being written returns the old word
`timescale 1ns/1ps
module dsb_mem #(
  parameter int DATA_W = 36,
  parameter int ADDR_W = 20,
  parameter int LANE_W = 9
) (
  // clock
  input  wire logic                      mclk,
  // write port
  input  wire logic                      wr_en,
  input  wire logic [ADDR_W-1:0]         wr_addr,
  input  wire logic [DATA_W-1:0]         wr_data,
  input  wire logic [DATA_W/LANE_W-1:0]  wr_lane_n,
  // read port
  input  wire logic                      rd_en,
  input  wire logic [ADDR_W-1:0]         rd_addr,
  output logic      [DATA_W-1:0]         rd_data
);
  localparam int LANES = DATA_W / LANE_W;

  logic [DATA_W-1:0] mem [0:(2**ADDR_W)-1];
  logic [DATA_W-1:0] merged;

  // ==========================================================
  // lane merge
  genvar g;
  generate
    for (g = 0; g < LANES; g++)
    begin : g_lane
      assign merged[g*LANE_W +: LANE_W] = wr_lane_n[g] ? mem[wr_addr][g*LANE_W +: LANE_W]
                                                        : wr_data[g*LANE_W +: LANE_W];
    end
  endgenerate

  // ==========================================================
  // array
  always_ff @(posedge mclk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= merged;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rd_en)
    begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// ===== rtl/dsb_skid.sv
// Purpose: two-entry buffer between array read and data output
// Assumes: occupancy is exported so the producer can hold off
// Notes:   out_data comes from the head register
`timescale 1ns/1ps
module dsb_skid #(
  parameter int W = 36
) (
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          sys_rst,
  // fill side
  input  wire logic          in_valid,
  output logic               in_ready,
  input  wire logic [W-1:0]  in_data,
  // drain side
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic      [W-1:0]  out_data,
  // level
  output logic      [1:0]    count
);
  logic [W-1:0] tail;
  logic         push;
  logic         pop;

  assign in_ready  = (count != 2'd2);
  assign out_valid = (count != 2'd0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // ==========================================================
  // occupancy
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      count <= 2'd0;
    else
      count <= count + {1'b0, push} - {1'b0, pop};
  end

  // ==========================================================
  // storage
  always_ff @(posedge mclk)
  begin
    if (pop)
      out_data <= (count == 2'd2) ? tail : in_data;
    else if (push && count == 2'd0)
      out_data <= in_data;
  end

  always_ff @(posedge mclk)
  begin
    if (push && ((count == 2'd1 && !pop) || count == 2'd2))
      tail <= in_data;
  end
endmodule

// ===== rtl/dsb_port.sv
// Purpose: command, address and data port of a two-word burst ddr sram
// Assumes: each mclk cycle is one beat; beat phase 0 is the k edge,
//          phase 1 the k-bar edge; inputs synchronous to mclk
// Notes:   reads are gated by rd_ready so the output buffer never overflows
`timescale 1ns/1ps

module dsb_port
  import dsb_pkg::*;
#(
  parameter int DATA_W = dsb_pkg::DSB_DATA_W_DEF,
  parameter int ADDR_W = dsb_pkg::DSB_ADDR_W_DEF
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  // command
  input  wire logic              cycle_strobe_n,
  input  wire logic              rw_dir,
  input  wire logic [ADDR_W-1:0] addr,
  output logic                   rd_ready,
  // write data and masks
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              low_nibble_mask_n,
  input  wire logic              high_nibble_mask_n,
  input  wire logic              byte0_mask_n,
  input  wire logic              byte1_mask_n,
  input  wire logic              byte2_mask_n,
  input  wire logic              byte3_mask_n,
  // read data
  input  wire logic              rd_accept,
  output logic      [DATA_W-1:0] rd_data,
  output logic                   rd_data_oe,
  // clocking
  input  wire logic              single_clock_mode,
  input  wire logic              out_clk_phase,
  output logic                   beat_phase,
  output logic                   echo_timing
);
  import dsb_pkg::*;

  localparam int  LANE_W = (DATA_W <= 8) ? DSB_NIB_LANE_W : DSB_BYTE_LANE_W;
  localparam int  LANES  = DATA_W / LANE_W;
  localparam bit  NIBBLE = (DATA_W <= 8);
  localparam int  WADR_W = ADDR_W + 1;

  dsb_state_e                state;
  dsb_state_e                next_state;
  logic       [ADDR_W-1:0]   burst_addr;
  logic       [DATA_W-1:0]   wr_hold;
  logic       [LANES-1:0]    mask_hold_n;
  logic       [DSB_MAX_LANES-1:0] mask_in_n;
  logic       [LANES-1:0]    lane_n;
  logic                      take_cmd;
  logic                      take_rd;
  logic                      take_wr;
  logic                      mem_wr_en;
  logic       [WADR_W-1:0]   mem_wr_addr;
  logic       [DATA_W-1:0]   mem_wr_data;
  logic       [LANES-1:0]    mem_wr_lane_n;
  logic                      mem_rd_en;
  logic       [WADR_W-1:0]   mem_rd_addr;
  logic       [DATA_W-1:0]   mem_rd_data;
  logic                      rd_resp;
  logic                      buf_in_ready;
  logic                      buf_out_valid;
  logic       [DATA_W-1:0]   buf_out_data;
  logic       [1:0]          buf_count;
  logic                      buf_pop;
  logic       [1:0]          occ_next;

  // ==========================================================
  // beat phase
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      beat_phase <= DSB_PHASE_K;
    else
      beat_phase <= ~beat_phase;
  end

  // ==========================================================
  // echo timing
  // free-running so the controller can train on it at any time
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      echo_timing <= DSB_RST_ECHO;
    else if (single_clock_mode)
      echo_timing <= ~beat_phase;
    else
      echo_timing <= out_clk_phase;
  end

  // ==========================================================
  // mask selection
  // nibble or byte lanes
  assign mask_in_n = NIBBLE ? {2'b11, high_nibble_mask_n, low_nibble_mask_n}
                            : {byte3_mask_n, byte2_mask_n, byte1_mask_n, byte0_mask_n};
  assign lane_n    = mask_in_n[LANES-1:0];

  // ==========================================================
  // command capture
  // only a low strobe on the k beat starts an access
  assign take_cmd = (beat_phase == DSB_PHASE_K) && !cycle_strobe_n && (state == DSB_IDLE);
  assign take_rd  = take_cmd && (rw_dir == DSB_RW_READ) && rd_ready;
  assign take_wr  = take_cmd && (rw_dir != DSB_RW_READ);

  // address latched only on an accepted access
  always_ff @(posedge mclk)
  begin
    if (take_rd || take_wr)
      burst_addr <= addr;
  end

  // ==========================================================
  // burst sequencer
  always_comb
  begin
    next_state = state;
    case (state)
      DSB_IDLE:
      begin
        if (take_wr)
          next_state = DSB_WR_SECOND;
        else if (take_rd)
          next_state = DSB_RD_SECOND;
      end
      DSB_WR_SECOND: next_state = DSB_IDLE;
      DSB_RD_SECOND: next_state = DSB_IDLE;
      default:       next_state = DSB_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      state <= DSB_IDLE;
    else
      state <= next_state;
  end

  // ==========================================================
  // write path
  // data and masks captured together on both beats of a write burst
  always_ff @(posedge mclk)
  begin
    if (take_wr || state == DSB_WR_SECOND)
    begin
      wr_hold     <= wr_data;
      mask_hold_n <= lane_n;
    end
  end

  logic wr_first_pend;
  logic wr_second_pend;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      wr_first_pend  <= 1'b0;
      wr_second_pend <= 1'b0;
    end
    else
    begin
      wr_first_pend  <= take_wr;
      wr_second_pend <= (state == DSB_WR_SECOND);
    end
  end

  // word 0 then word 1 of the burst
  assign mem_wr_en     = wr_first_pend || wr_second_pend;
  assign mem_wr_addr   = {burst_addr, wr_second_pend};
  assign mem_wr_data   = wr_hold;
  assign mem_wr_lane_n = mask_hold_n;

  // ==========================================================
  // read path
  // array holds two words per burst address
  assign mem_rd_en   = take_rd || (state == DSB_RD_SECOND);
  // word 0 on k beat, word 1 on k-bar beat
  assign mem_rd_addr = take_rd ? {addr, 1'b0} : {burst_addr, 1'b1};

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      rd_resp <= 1'b0;
    else
      rd_resp <= mem_rd_en;
  end

  dsb_mem #(
    .DATA_W (DATA_W),
    .ADDR_W (WADR_W),
    .LANE_W (LANE_W)
  ) u_mem (
    .mclk      (mclk),
    .wr_en     (mem_wr_en),
    .wr_addr   (mem_wr_addr),
    .wr_data   (mem_wr_data),
    .wr_lane_n (mem_wr_lane_n),
    .rd_en     (mem_rd_en),
    .rd_addr   (mem_rd_addr),
    .rd_data   (mem_rd_data)
  );

  dsb_skid #(
    .W (DATA_W)
  ) u_buf (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .in_valid  (rd_resp),
    .in_ready  (buf_in_ready),
    .in_data   (mem_rd_data),
    .out_valid (buf_out_valid),
    .out_ready (rd_accept),
    .out_data  (buf_out_data),
    .count     (buf_count)
  );

  // ==========================================================
  // read admission
  // a read is let in only when the buffer will be empty, so both
  // words always find room even if rd_accept stays low; the cost is
  // one idle k period between back-to-back reads
  assign buf_pop  = buf_out_valid && rd_accept;
  assign occ_next = buf_count + {1'b0, rd_resp && buf_in_ready} - {1'b0, buf_pop};

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      rd_ready <= DSB_RST_RDY;
    else
      rd_ready <= (occ_next == 2'd0) && !mem_rd_en;
  end

  // ==========================================================
  // output drive
  // one word per beat while data is flowing
  always_ff @(posedge mclk)
  begin
    if (buf_pop)
      rd_data <= buf_out_data;
  end

  // outputs released when nothing is being read
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      rd_data_oe <= DSB_RST_OE;
    else
      rd_data_oe <= buf_pop;
  end
endmodule

// ===== tb/dsb_port_chk.sv
// Purpose: port checks for dsb_port
// Assumes: one clock, sync reset
// Notes:   read timing holds only with rd_accept high
`timescale 1ns/1ps
module dsb_port_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // command and read side
  input wire logic cycle_strobe_n,
  input wire logic rw_dir,
  input wire logic rd_ready,
  input wire logic rd_accept,
  input wire logic rd_data_oe,
  // clocking
  input wire logic beat_phase,
  input wire logic echo_timing
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // ====
  // sequences
  sequence s_rd_cmd;
    !beat_phase && !cycle_strobe_n && rw_dir && rd_ready;
  endsequence
  sequence s_rd_flow;
    (!beat_phase && !cycle_strobe_n && rw_dir && rd_ready && rd_accept) ##1 rd_accept [*3];
  endsequence
  sequence s_two_words;
    (rd_data_oe && rd_accept) ##1 (rd_data_oe && rd_accept);
  endsequence
  // ====
  // properties
  a_beat_alternates: assert property (
    !$past(sys_rst) |-> beat_phase != $past(beat_phase)) else $error("beat phase stuck");
  a_reset_values: assert property (
    $past(sys_rst) |-> !rd_data_oe && rd_ready && !beat_phase && !echo_timing)
    else $error("bad values after reset");
  a_read_words: assert property (
    s_rd_flow |-> rd_data_oe ##1 rd_data_oe ##1 !rd_data_oe) else $error("read words late");
  a_ready_drops: assert property (
    s_rd_cmd |=> !rd_ready) else $error("read not taken");
  a_write_keeps: assert property (
    !beat_phase && !cycle_strobe_n && !rw_dir && rd_ready |=> rd_ready)
    else $error("write taken as read");
  a_odd_ignored: assert property (
    beat_phase && !cycle_strobe_n && rw_dir && rd_ready && $past(cycle_strobe_n) |=> rd_ready)
    else $error("strobe on odd beat taken");
  a_two_only: assert property (
    s_two_words |=> !rd_data_oe) else $error("more than two words");
  a_idle_quiet: assert property (
    (cycle_strobe_n && rd_ready) [*6] |-> !rd_data_oe) else $error("output driven idle");
  a_echo_runs: assert property (
    1'b1 |-> ##[1:4] $changed(echo_timing)) else $error("echo timing stopped");
endmodule

// ===== tb/dsb_ctrl_model.sv
// Purpose: memory controller facing dsb_port
// Assumes: drives at falling edge, commands on phase 0 beats except from stray, which strobes on phase 1
// Notes:   idle lines show inverted values, not the last ones
`timescale 1ns/1ps
module dsb_ctrl_model #(
  parameter int DATA_W = 36,
  parameter int ADDR_W = 19
) (
  // clock
  input wire logic              mclk,
  // from device
  input wire logic              beat_phase,
  input wire logic              rd_ready,
  input wire logic              rd_data_oe,
  input wire logic [DATA_W-1:0] rd_data,
  // to device
  output logic                  cycle_strobe_n,
  output logic                  rw_dir,
  output logic     [ADDR_W-1:0] addr,
  output logic     [DATA_W-1:0] wr_data,
  output logic                  low_nibble_mask_n,
  output logic                  high_nibble_mask_n,
  output logic                  byte0_mask_n,
  output logic                  byte1_mask_n,
  output logic                  byte2_mask_n,
  output logic                  byte3_mask_n,
  output logic                  rd_accept,
  output logic                  out_clk_phase
);
  logic stall_ready;
  initial
  begin
    {low_nibble_mask_n, high_nibble_mask_n, rd_accept, stall_ready} = 4'hf;
    out_clk_phase = 1'b0;
    drive(1'b1, 1'b1, '0, '0, 4'hf);
  end
  // free-running output clock
  // x-safe toggle: a time-zero clock event may run before the initial block
  always @(negedge mclk)
    out_clk_phase <= (out_clk_phase !== 1'b1);
  // ====
  // bus tasks
  task automatic drive(input logic s, r, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] w, input logic [3:0] m);
    cycle_strobe_n = s;
    rw_dir = r;
    addr = a;
    wr_data = w;
    {byte3_mask_n, byte2_mask_n, byte1_mask_n, byte0_mask_n} = m;
  endtask
  // strobe high on every idle beat
  task automatic slot(input bit rd, output bit ok);
    ok = 0;
    for (int i = 0; i < 20 && !ok; i++)
    begin
      @(negedge mclk);
      ok = !beat_phase && (!rd || rd_ready);
      if (!ok)
        drive(1'b1, 1'b1, ~addr, ~wr_data, 4'hf);
    end
  endtask
  // word0 on phase 0, word1 and its mask next beat
  task automatic write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] w0, w1,
                       input logic [3:0] m0, m1, output bit ok);
    slot(1'b0, ok);
    drive(1'b0, 1'b0, a, w0, m0);
    @(negedge mclk);
    drive(1'b1, 1'b1, ~a, w1, m1);
  endtask
  task automatic read(input logic [ADDR_W-1:0] a, input int stall,
                      output logic [DATA_W-1:0] w0, w1, output bit ok);
    int n;
    n = 0;
    slot(1'b1, ok);
    drive(1'b0, 1'b1, a, ~wr_data, 4'hf);
    rd_accept = (stall == 0);
    for (int i = 0; i < 24 && n < 2; i++)
    begin
      @(negedge mclk);
      drive(1'b1, 1'b0, ~addr, ~wr_data, 4'hf);
      if (i == stall - 1)
        stall_ready = rd_ready;
      if (i >= stall)
        rd_accept = 1'b1;
      if (rd_data_oe && rd_accept)
      begin
        if (n == 0)
          w0 = rd_data;
        else
          w1 = rd_data;
        n++;
      end
    end
    ok = ok && (n == 2);
  endtask
  // strobe on a phase 1 beat, wrong on purpose
  task automatic stray(input logic r, input logic [ADDR_W-1:0] a, output bit ok);
    ok = 0;
    for (int i = 0; i < 4 && !ok; i++)
    begin
      @(negedge mclk);
      ok = beat_phase;
    end
    drive(1'b0, r, a, '0, 4'h0);
    @(negedge mclk);
    drive(1'b1, 1'b1, ~a, '1, 4'hf);
  endtask
endmodule

// ===== tb/testbench.sv
// Purpose: self-checking bench for dsb_port
// Assumes: 36-bit variant, inputs change at falling edge
// Notes:   narrow nibble lanes are not reached here
`timescale 1ns/1ps
module testbench;
  import dsb_pkg::*;
  localparam int DW = 36;
  localparam int AW = 19;
  logic          mclk = 1'b0;
  logic          sys_rst = 1'b1;
  logic          single_clock_mode = 1'b1;
  logic          cycle_strobe_n, rw_dir, rd_ready, rd_accept, rd_data_oe, out_clk_phase;
  logic          low_nibble_mask_n, high_nibble_mask_n, beat_phase, echo_timing;
  logic          byte0_mask_n, byte1_mask_n, byte2_mask_n, byte3_mask_n;
  logic [AW-1:0] addr;
  logic [DW-1:0] wr_data, rd_data, p0, p1;
  int            errors = 0;
  int            samples_checked = 0;
  always #5 mclk = ~mclk;
  dsb_port #(.DATA_W(DW), .ADDR_W(AW)) dsb_port_inst (.mclk, .sys_rst, .cycle_strobe_n,
    .rw_dir, .addr, .rd_ready, .wr_data, .low_nibble_mask_n, .high_nibble_mask_n,
    .byte0_mask_n, .byte1_mask_n, .byte2_mask_n, .byte3_mask_n, .rd_accept, .rd_data,
    .rd_data_oe, .single_clock_mode, .out_clk_phase, .beat_phase, .echo_timing);
  dsb_ctrl_model #(.DATA_W(DW), .ADDR_W(AW)) dsb_ctrl_model_inst (.mclk, .beat_phase,
    .rd_ready, .rd_data_oe, .rd_data, .cycle_strobe_n, .rw_dir, .addr, .wr_data,
    .low_nibble_mask_n, .high_nibble_mask_n, .byte0_mask_n, .byte1_mask_n, .byte2_mask_n,
    .byte3_mask_n, .rd_accept, .out_clk_phase);
  // ====
  // checking
  task automatic chk_word(input logic [DW-1:0] got, exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic need(input bit ok);
    chk_flag(ok, 1'b1);
    if (!ok)
      conclude();
  endtask
  function automatic logic [DW-1:0] merge(input logic [DW-1:0] o, n, input logic [3:0] m);
    merge = o;
    for (int l = 0; l < 4; l++)
      if (!m[l])
        merge[l*9 +: 9] = n[l*9 +: 9];
  endfunction
  // ====
  // operations
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] w0, w1,
                    input logic [3:0] m0, m1);
    bit ok;
    dsb_ctrl_model_inst.write(a, w0, w1, m0, m1, ok);
    need(ok);
  endtask
  task automatic rd(input logic [AW-1:0] a, input int stall, input logic [DW-1:0] e0, e1);
    bit ok;
    logic [DW-1:0] g0, g1;
    dsb_ctrl_model_inst.read(a, stall, g0, g1, ok);
    need(ok);
    chk_word(g0, e0);
    chk_word(g1, e1);
  endtask
  // ====
  // scenarios
  task automatic t_reset;
    sys_rst = 1'b1;
    repeat (4) @(negedge mclk);
    chk_flag(rd_data_oe | beat_phase | echo_timing | ~rd_ready, 1'b0);
    sys_rst = 1'b0;
  endtask
  task automatic t_burst;
    p0 = 36'h123456789;
    p1 = 36'hfedcba987;
    wr(19'h00005, p0, p1, 4'h0, 4'h0);
    wr(19'h00006, ~p0, ~p1, 4'h0, 4'h0);
    wr('1, p1, p0, 4'h0, 4'h0);
    rd(19'h00005, 0, p0, p1);
    rd(19'h00006, 0, ~p0, ~p1);
    rd('1, 0, p1, p0);
  endtask
  task automatic t_mask;
    wr(19'h00009, 36'h0, 36'h0, 4'h0, 4'h0);
    wr(19'h00009, p0, p1, 4'h5, 4'ha);
    rd(19'h00009, 0, merge('0, p0, 4'h5), merge('0, p1, 4'ha));
  endtask
  task automatic t_stray;
    bit ok;
    dsb_ctrl_model_inst.stray(1'b0, 19'h00009, ok);
    need(ok);
    dsb_ctrl_model_inst.stray(1'b1, 19'h00009, ok);
    need(ok);
    chk_flag(rd_ready, 1'b1);
    rd(19'h00009, 0, merge('0, p0, 4'h5), merge('0, p1, 4'ha));
  endtask
  task automatic t_stall;
    rd(19'h00005, 6, p0, p1);
    chk_flag(dsb_ctrl_model_inst.stall_ready, 1'b0);
    rd(19'h00006, 0, ~p0, ~p1);
  endtask
  task automatic t_echo(input logic mode);
    int n;
    logic e;
    n = 0;
    single_clock_mode = mode;
    e = echo_timing;
    repeat (16)
    begin
      @(negedge mclk);
      n += (echo_timing !== e);
      e = echo_timing;
    end
    chk_flag(n >= 14, 1'b1);
    // echo in step with the beat, or with the outside clock
    chk_flag(echo_timing, mode ? beat_phase : out_clk_phase);
    rd(19'h00005, 0, p0, p1);
  endtask
  task automatic t_again;
    t_reset();
    wr(19'h00003, p1, p0, 4'h0, 4'h0);
    rd(19'h00003, 0, p1, p0);
  endtask
  initial
  begin
    t_reset();
    t_burst();
    t_mask();
    t_stray();
    t_stall();
    t_echo(1'b0);
    t_echo(1'b1);
    t_again();
    conclude();
  end
endmodule
bind dsb_port dsb_port_chk dsb_port_chk_inst (.mclk, .sys_rst, .cycle_strobe_n, .rw_dir,
  .rd_ready, .rd_accept, .rd_data_oe, .beat_phase, .echo_timing);
